// ==== inc/pwr_clk_pkg.sv ====
package pwr_clk_pkg;

    // ==========================================================================
    // Register map
    localparam logic [3:0]  OFF_CFG_WORD  = 4'h0;
    localparam logic [3:0]  OFF_PWR_CTRL  = 4'h4;
    localparam logic [3:0]  OFF_PWR_STAT  = 4'h8;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ==========================================================================
    // Configuration word fields
    localparam int          CSM_LSB       = 14;
    localparam int          PBDIV_LSB     = 12;
    localparam int          CLOCK_OUTPUT_CFG_BIT  = 10;
    localparam int          POSC_LSB      = 8;
    localparam int          TWO_SPEED_BIT = 7;
    localparam int          SOSC_EN_BIT   = 5;
    localparam int          OSC_SEL_LSB   = 0;
    localparam logic [31:0] CFG_RST       = 32'hFFFF_FFFF;

    localparam logic [1:0]  POSC_OFF      = 2'h3;
    localparam logic [1:0]  POSC_HS       = 2'h2;
    localparam logic [1:0]  POSC_XT       = 2'h1;
    localparam logic [1:0]  POSC_EC       = 2'h0;

    localparam logic [2:0]  OSC_FRC_DIVN  = 3'h7;
    localparam logic [2:0]  OSC_FRC_DIV16 = 3'h6;
    localparam logic [2:0]  OSC_LOW_POWER_RC_SOURCE      = 3'h5;
    localparam logic [2:0]  OSC_SOSC      = 3'h4;
    localparam logic [2:0]  OSC_POSC_PLL  = 3'h3;
    localparam logic [2:0]  OSC_POSC      = 3'h2;
    localparam logic [2:0]  OSC_FRCN_PLL  = 3'h1;
    localparam logic [2:0]  OSC_FRC       = 3'h0;

    // ==========================================================================
    // Power control and status fields
    localparam int          CTRL_SLEEP_BIT  = 0;
    localparam int          CTRL_PBDIV_LSB  = 4;
    localparam int          CTRL_OSC_LSB    = 8;
    localparam int          CTRL_SWITCH_BIT = 11;
    localparam int          STAT_MODE_LSB   = 0;
    localparam int          STAT_OSC_LSB    = 4;
    localparam int          STAT_FAIL_SAFE_CLK_MONITOR_BIT   = 8;
    localparam int          STAT_SRC_BIT    = 9;
    localparam int          STAT_TWO_SP_BIT = 10;

    // ==========================================================================
    // Timing
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          XTAL_START_NS  = 1000;
    localparam int          RC_START_NS    = 100;
    localparam int          XTAL_START_CYC = (XTAL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RC_START_CYC   = (RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TMR_W          = 8;

    typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP, PM_WAKE} pm_state_t;

endpackage

// ==== src/pb_divider.sv ====
`timescale 1ns/1ps

module pb_divider
    import pwr_clk_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       enable,
    input  wire logic [1:0] div_sel,
    output logic            tick
);

    typedef struct packed {
        logic [2:0] cnt;
    } div_state_t;

    div_state_t q;
    div_state_t d;
    logic [2:0] last;

    // The last count is 2^div_sel - 1, so the tick falls every 1, 2, 4 or 8 cycles.
    always_comb
    begin
        last = 3'(({1'b0, 3'h1} << div_sel) - 4'h1);
        d    = q;
        if (!aresetn || !enable || q.cnt >= last)
        begin
            d.cnt = 3'h0;
        end
        else
        begin
            d.cnt = q.cnt + 3'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        q <= d;
    end

    assign tick = enable && (q.cnt >= last);

endmodule // pb_divider

// ==== src/startup_timer.sv ====
`timescale 1ns/1ps

module startup_timer
    import pwr_clk_pkg::*;
#(
    parameter int W = TMR_W
)
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    output logic              done
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
    } tmr_state_t;

    tmr_state_t q;
    tmr_state_t d;

    always_comb
    begin
        d = q;
        if (!aresetn)
        begin
            d = '0;
        end
        else if (start)
        begin
            d.cnt  = load;
            d.busy = 1'b1;
        end
        else if (q.busy)
        begin
            d.cnt  = q.cnt - 1'b1;
            d.busy = (q.cnt > 1);
        end
    end

    always_ff @(posedge aclk)
    begin
        q <= d;
    end

    assign done = !q.busy && !start;

endmodule // startup_timer

// ==== src/pwr_clk_ctrl.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Switch/monitor field: 1x neither, 01 switching only, 00 switching and monitor.
// RULE_02: Default peripheral bus divisor field: 00 /1, 01 /2, 10 /4, 11 /8.
// RULE_03: Clock output drives the pin when its bit is 0 and primary mode is 11 or 00.
// RULE_04: Primary oscillator mode: 11 off, 10 high-speed, 01 crystal, 00 external clock.
// RULE_05: Switchover bit 1 starts on the internal clock, then moves to the external one.
// RULE_06: Secondary oscillator runs only while its enable bit is 1.
// RULE_07: Three-bit startup oscillator selection picks one of eight sources.
// RULE_08: Software must not disable primary while it is the selected source.
// RULE_09: The programmer writes ones into reserved bits 11, 6 and 4-3.
// RULE_10: Sleep stops the CPU clock, the system source and system-clocked peripherals.
// RULE_11: The fail-safe monitor is inactive throughout Sleep.
// RULE_12: Entering Sleep never clears the watchdog counter.
// RULE_13: Idle gates only the CPU clock; source and peripherals keep running.
// RULE_14: Peripherals may run from a programmable fraction of the system clock.
// RULE_15: The CPU may run from fast RC, low-power RC or the secondary oscillator.
// RULE_16: USB may keep primary or fast RC sources running in Sleep.
// RULE_17: Wake-up events end Sleep after a delay set by the oscillator type.
// RULE_18: Pins keep their driven state throughout Sleep.
// RULE_19: Software commands every power-saving entry and may disable modules first.
// RULE_20: A control bit, sampled at the halt request, picks Sleep or Idle.
// RULE_21: On wake the source restarts and settles before the CPU clock returns.
module pwr_clk_ctrl
    import pwr_clk_pkg::*;
#(
    parameter int IO_W = 8
)
(
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic [3:0]      awaddr,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    input  wire logic [3:0]      araddr,
    input  wire logic            arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  wire logic            rready,
    input  wire logic [31:0]     cfg_word,
    input  wire logic            cpu_halt_req,
    input  wire logic            wake_event,
    input  wire logic            osc_ready,
    input  wire logic            usb_keep_osc,
    input  wire logic            wdt_clear_req,
    input  wire logic [IO_W-1:0] io_out_in,
    output logic                 cpu_clk_en,
    output logic                 system_clock_src_en,
    output logic                 periph_clk_en,
    output logic                 pb_clk_en,
    output logic                 fail_safe_clk_monitor_en,
    output logic                 clk_switch_en,
    output logic                 clk_out_en,
    output logic                 posc_en,
    output logic                 posc_hs_mode,
    output logic                 posc_xt_mode,
    output logic                 posc_ec_mode,
    output logic                 sosc_en,
    output logic                 pll_en,
    output logic [2:0]           osc_sel,
    output logic                 two_speed_active,
    output logic                 wdt_clear,
    output logic [IO_W-1:0]      io_out
);

    // ==========================================================================
    // State
    typedef struct packed {
        logic [31:0]     cfg;
        pm_state_t       st;
        logic            boot;
        logic            two_sp;
        logic [2:0]      osc;
        logic            sleep_sel;
        logic [1:0]      pb_div;
        logic [1:0]      wake_s;
        logic [1:0]      ordy_s;
        logic            wdt_clr;
        logic [IO_W-1:0] io;
        logic            aw_held;
        logic [3:0]      aw_addr;
        logic            w_held;
        logic [31:0]     w_data;
        logic [3:0]      w_strb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
    } ctl_state_t;

    ctl_state_t q;
    ctl_state_t d;

    logic [1:0]       posc_mode;
    logic [2:0]       boot_sel;
    logic             posc_src;
    logic             frc_src;
    logic             src_kept;
    logic             tmr_start;
    logic [TMR_W-1:0] tmr_load;
    logic             tmr_done;
    logic             aw_go;
    logic             w_go;
    logic             do_wr;
    logic [3:0]       wr_addr;
    logic [31:0]      wr_data;
    logic [3:0]       wr_strb;
    logic [31:0]      stat_word;

    // ==========================================================================
    // Configuration decode
    assign posc_mode     = q.cfg[POSC_LSB +: 2];
    assign boot_sel      = q.cfg[OSC_SEL_LSB +: 3];
    assign clk_switch_en = !q.cfg[CSM_LSB + 1]; // RULE_01
    // The monitor has no reference to watch while the source is stopped.
    assign fail_safe_clk_monitor_en       = (q.cfg[CSM_LSB +: 2] == 2'h0) && (q.st != PM_SLEEP); // RULE_01 RULE_11
    assign posc_hs_mode  = (posc_mode == POSC_HS); // RULE_04
    assign posc_xt_mode  = (posc_mode == POSC_XT); // RULE_04
    assign posc_ec_mode  = (posc_mode == POSC_EC); // RULE_04
    assign clk_out_en    = !q.cfg[CLOCK_OUTPUT_CFG_BIT]
                           && (posc_mode == POSC_OFF || posc_mode == POSC_EC); // RULE_03
    assign posc_src      = (q.osc == OSC_POSC) || (q.osc == OSC_POSC_PLL);
    assign frc_src       = !posc_src && (q.osc != OSC_SOSC) && (q.osc != OSC_LOW_POWER_RC_SOURCE);
    assign src_kept      = usb_keep_osc && (posc_src || frc_src); // RULE_16

    // ==========================================================================
    // Clock gating outputs
    assign cpu_clk_en       = (q.st == PM_RUN); // RULE_10 RULE_13
    assign system_clock_src_en    = (q.st != PM_SLEEP) || src_kept; // RULE_10 RULE_13 RULE_16
    assign periph_clk_en    = (q.st == PM_RUN) || (q.st == PM_IDLE); // RULE_10 RULE_13
    assign posc_en          = (posc_mode != POSC_OFF) && system_clock_src_en
                              && (posc_src || q.two_sp); // RULE_04 RULE_05
    assign sosc_en          = q.cfg[SOSC_EN_BIT]; // RULE_06
    assign pll_en           = system_clock_src_en
                              && (q.osc == OSC_POSC_PLL || q.osc == OSC_FRCN_PLL); // RULE_07
    assign osc_sel          = q.osc;
    assign two_speed_active = q.two_sp;
    assign wdt_clear        = q.wdt_clr;
    assign io_out           = q.io;

    pb_divider u_pb_divider (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (periph_clk_en),
        .div_sel (q.pb_div),
        .tick    (pb_clk_en)
    ); // RULE_14

    // Crystals need far longer to settle than the RC sources.
    assign tmr_load  = (posc_src && posc_mode != POSC_EC) || (q.osc == OSC_SOSC)
                       ? TMR_W'(XTAL_START_CYC) : TMR_W'(RC_START_CYC); // RULE_17
    assign tmr_start = (q.st == PM_SLEEP) && q.wake_s[1] && !src_kept; // RULE_21

    startup_timer u_startup_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (tmr_start),
        .load    (tmr_load),
        .done    (tmr_done)
    );

    // ==========================================================================
    // Bus handshakes
    assign awready = !q.aw_held && !q.bvalid;
    assign wready  = !q.w_held && !q.bvalid;
    assign arready = !q.rvalid;
    assign bvalid  = q.bvalid;
    assign bresp   = q.bresp;
    assign rvalid  = q.rvalid;
    assign rdata   = q.rdata;
    assign rresp   = q.rresp;
    assign aw_go   = q.aw_held || (awvalid && awready);
    assign w_go    = q.w_held || (wvalid && wready);
    assign do_wr   = aw_go && w_go && !q.bvalid;
    assign wr_addr = q.aw_held ? q.aw_addr : awaddr;
    assign wr_data = q.w_held ? q.w_data : wdata;
    assign wr_strb = q.w_held ? q.w_strb : wstrb;

    always_comb
    begin
        stat_word                          = '0;
        stat_word[STAT_MODE_LSB +: 2]      = q.st;
        stat_word[STAT_OSC_LSB +: 3]       = q.osc;
        stat_word[STAT_FAIL_SAFE_CLK_MONITOR_BIT]           = fail_safe_clk_monitor_en;
        stat_word[STAT_SRC_BIT]            = system_clock_src_en;
        stat_word[STAT_TWO_SP_BIT]         = q.two_sp;
    end

    // ==========================================================================
    // Next state
    always_comb
    begin
        d        = q;
        d.cfg    = cfg_word;
        d.wake_s = {q.wake_s[0], wake_event};
        d.ordy_s = {q.ordy_s[0], osc_ready};
        // Sleep entry leaves the watchdog alone; only the CPU's own request clears it.
        d.wdt_clr = wdt_clear_req; // RULE_12
        if (q.st != PM_SLEEP)
        begin
            d.io = io_out_in;
        end // RULE_18

        // Startup source and default bus divisor, taken once the word is loaded.
        if (q.boot)
        begin
            d.boot   = 1'b0;
            d.pb_div = q.cfg[PBDIV_LSB +: 2]; // RULE_02
            if (q.cfg[TWO_SPEED_BIT]
                && (boot_sel == OSC_POSC || boot_sel == OSC_POSC_PLL))
            begin
                d.osc    = OSC_FRC;
                d.two_sp = 1'b1; // RULE_05
            end
            else
            begin
                d.osc = boot_sel; // RULE_07
            end
        end
        else if (q.two_sp && q.ordy_s[1])
        begin
            d.two_sp = 1'b0;
            d.osc    = boot_sel; // RULE_05
        end

        case (q.st)
            PM_RUN:
            begin
                if (cpu_halt_req)
                begin
                    d.st = q.sleep_sel ? PM_SLEEP : PM_IDLE; // RULE_20
                end
            end
            PM_IDLE:
            begin
                if (q.wake_s[1])
                begin
                    d.st = PM_RUN;
                end
            end
            PM_SLEEP:
            begin
                if (q.wake_s[1])
                begin
                    d.st = src_kept ? PM_RUN : PM_WAKE; // RULE_17
                end
            end
            PM_WAKE:
            begin
                if (tmr_done && q.ordy_s[1])
                begin
                    d.st = PM_RUN; // RULE_21
                end
            end
            default:
            begin
                d.st = PM_RUN;
            end
        endcase

        // Write channel: address and data may arrive in either order.
        if (awvalid && awready && !do_wr)
        begin
            d.aw_held = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready && !do_wr)
        begin
            d.w_held = 1'b1;
            d.w_data = wdata;
            d.w_strb = wstrb;
        end
        if (do_wr)
        begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = RESP_OKAY;
            if (wr_addr == OFF_PWR_CTRL)
            begin
                if (wr_strb[0])
                begin
                    d.sleep_sel = wr_data[CTRL_SLEEP_BIT];
                    d.pb_div    = wr_data[CTRL_PBDIV_LSB +: 2]; // RULE_14
                end
                // A switch request is dropped when switching is locked out.
                if (wr_strb[1] && wr_data[CTRL_SWITCH_BIT] && clk_switch_en
                    && q.st == PM_RUN && !q.two_sp && !q.boot)
                begin
                    d.osc = wr_data[CTRL_OSC_LSB +: 3]; // RULE_15
                end
            end
            else
            begin
                d.bresp = RESP_SLVERR;
            end
        end
        else if (q.bvalid && bready)
        begin
            d.bvalid = 1'b0;
        end

        if (arvalid && arready)
        begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            case (araddr)
                OFF_CFG_WORD: d.rdata = q.cfg;
                OFF_PWR_CTRL: d.rdata = {20'h0, 1'b0, q.osc, 2'h0, q.pb_div,
                                         3'h0, q.sleep_sel};
                OFF_PWR_STAT: d.rdata = stat_word;
                default:
                begin
                    d.rdata = '0;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (q.rvalid && rready)
        begin
            d.rvalid = 1'b0;
        end

        if (!aresetn)
        begin
            d        = '0;
            d.cfg    = cfg_word;
            d.st     = PM_RUN;
            d.boot   = 1'b1;
            d.osc    = OSC_FRC;
        end
    end

    always_ff @(posedge aclk)
    begin
        q <= d;
    end

    // ==========================================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_fail_safe_clk_monitor_sleep: assert property (q.st == PM_SLEEP |-> !fail_safe_clk_monitor_en) // RULE_11
        else $error("Clock monitor active in sleep.");
    chk_fail_safe_clk_monitor_decode: assert property (fail_safe_clk_monitor_en |-> q.cfg[CSM_LSB +: 2] == 2'h0) // RULE_01
        else $error("Clock monitor enabled by wrong field code.");
    chk_clk_out_gate: assert property (clk_out_en |-> !q.cfg[CLOCK_OUTPUT_CFG_BIT]
        && (posc_mode == POSC_OFF || posc_mode == POSC_EC)) // RULE_03
        else $error("Clock output enabled in a crystal mode.");
    chk_sleep_gating: assert property (q.st == PM_SLEEP
        |-> !cpu_clk_en && !periph_clk_en && (system_clock_src_en == src_kept)) // RULE_10
        else $error("Clocks still running in sleep.");
    chk_idle_gating: assert property (q.st == PM_IDLE
        |-> !cpu_clk_en && system_clock_src_en && periph_clk_en) // RULE_13
        else $error("Idle gates more than the CPU clock.");
    chk_halt_choice: assert property (q.st == PM_RUN && cpu_halt_req
        |=> q.st == ($past(q.sleep_sel) ? PM_SLEEP : PM_IDLE)) // RULE_20
        else $error("Halt entered the wrong mode.");
    chk_wake_order: assert property (q.st == PM_WAKE && !(tmr_done && q.ordy_s[1])
        |=> q.st == PM_WAKE) // RULE_21
        else $error("CPU clock back before the source settled.");
    chk_io_held: assert property (q.st == PM_SLEEP ##1 q.st == PM_SLEEP
        |-> $stable(io_out)) // RULE_18
        else $error("Pin state changed in sleep.");
    chk_pb_full_rate: assert property (periph_clk_en && q.pb_div == 2'h0
        |-> pb_clk_en) // RULE_02
        else $error("Bus clock missing a tick at divide by one.");
    chk_usb_keep: assert property (q.st == PM_SLEEP && src_kept |-> system_clock_src_en) // RULE_16
        else $error("Source stopped while held by USB.");
    chk_wdt_untouched: assert property (wdt_clear |-> $past(wdt_clear_req)) // RULE_12
        else $error("Watchdog cleared without a request.");

endmodule // pwr_clk_ctrl

// ==== verif/pwr_clk_ctrl_tb.sv ====
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) \
        begin \
            n_mismatch++; \
            $display("ERROR %s exp %0h got %0h", nm, ex, got); \
        end \
    end

module pwr_clk_ctrl_tb;
    import pwr_clk_pkg::*;

    // ==========================================================================
    // Stimulus and observed signals
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, cpu_halt_req = 1'b0, wake_event = 1'b0;
    logic        osc_ready = 1'b1, usb_keep_osc = 1'b0, wdt_clear_req = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, cfg_word = CFG_RST, rdata, d, c;
    logic [7:0]  io_out_in = 8'h00, io_out;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  osc_sel;
    logic        awready, wready, bvalid, arready, rvalid, cpu_clk_en, system_clock_src_en;
    logic        periph_clk_en, pb_clk_en, fail_safe_clk_monitor_en, clk_switch_en, clk_out_en, posc_en;
    logic        posc_hs_mode, posc_xt_mode, posc_ec_mode, sosc_en, pll_en;
    logic        two_speed_active, wdt_clear;
    int          n_mismatch = 0, tests_run = 0, n, i, k;

    always #12.5 aclk = ~aclk;

    pwr_clk_ctrl u_pwr_clk_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .cfg_word(cfg_word), .cpu_halt_req(cpu_halt_req),
        .wake_event(wake_event), .osc_ready(osc_ready), .usb_keep_osc(usb_keep_osc),
        .wdt_clear_req(wdt_clear_req), .io_out_in(io_out_in), .cpu_clk_en(cpu_clk_en),
        .system_clock_src_en(system_clock_src_en), .periph_clk_en(periph_clk_en), .pb_clk_en(pb_clk_en),
        .fail_safe_clk_monitor_en(fail_safe_clk_monitor_en), .clk_switch_en(clk_switch_en), .clk_out_en(clk_out_en),
        .posc_en(posc_en), .posc_hs_mode(posc_hs_mode), .posc_xt_mode(posc_xt_mode),
        .posc_ec_mode(posc_ec_mode), .sosc_en(sosc_en), .pll_en(pll_en), .osc_sel(osc_sel),
        .two_speed_active(two_speed_active), .wdt_clear(wdt_clear), .io_out(io_out));

    // ==========================================================================
    // Bus and sequencing tasks
    task automatic axw(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!(bvalid && bready));
        bready <= 1'b0;
        rs = bresp;
    endtask

    task automatic axr(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!(rvalid && rready));
        rready <= 1'b0;
        dat = rdata;
        rs = rresp;
    endtask

    // Reserved bits are forced to ones and a disabled primary is never paired with it.
    function automatic logic [31:0] mkcfg(input logic [2:0] sel, input logic ts);
        logic [31:0] v;
        v = $urandom;
        v[11] = 1'b1;
        v[6] = 1'b1;
        v[4:3] = 2'b11;
        v[7] = ts;
        v[2:0] = sel;
        if ((sel == OSC_POSC || sel == OSC_POSC_PLL) && v[9:8] == POSC_OFF)
            v[9:8] = POSC_HS;
        return v;
    endfunction

    task automatic rst(input logic [31:0] cv);
        @(posedge aclk);
        cfg_word <= cv;
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask

    // Any window of 16 cycles holds exactly 16 / divisor ticks, whatever the phase.
    task automatic pbc(output int cnt);
        cnt = 0;
        repeat (16)
        begin
            @(negedge aclk);
            cnt += int'(pb_clk_en === 1'b1);
        end
    endtask

    task automatic hlt(input logic s);
        axw(OFF_PWR_CTRL, {31'h0, s}, r);
        @(posedge aclk);
        cpu_halt_req <= 1'b1;
        @(posedge aclk);
        cpu_halt_req <= 1'b0;
        @(negedge aclk);
    endtask

    task automatic wake(input int lim);
        @(posedge aclk);
        wake_event <= 1'b1;
        repeat (4) @(posedge aclk);
        wake_event <= 1'b0;
        for (k = 0; k < lim && cpu_clk_en !== 1'b1; k++) @(negedge aclk);
    endtask

    task automatic results;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================================
    // Scenarios
    initial
    begin
        repeat (6000) @(posedge aclk);
        n_mismatch++;
        results();
    end

    initial
    begin
        void'($urandom(32'h1C9E));
        for (i = 0; i < 8; i++)
        begin
            c = mkcfg(i[2:0], 1'b0);
            rst(c);
            `CHK("osc_sel", i[2:0], osc_sel);
            `CHK("pll_en", (i == 1 || i == 3), pll_en);
            `CHK("cpu_run", 1'b1, cpu_clk_en);
            `CHK("switch", ~c[15], clk_switch_en);
            `CHK("fail_safe_clk_monitor", c[15:14] == 2'b00, fail_safe_clk_monitor_en);
            `CHK("clk_out", !c[10] && (c[9:8] == 2'b11 || c[9:8] == 2'b00), clk_out_en);
            `CHK("modes", {c[9:8] == 2'b10, c[9:8] == 2'b01, c[9:8] == 2'b00}, {posc_hs_mode, posc_xt_mode, posc_ec_mode});
            `CHK("posc_en", c[9:8] != 2'b11 && (i == 2 || i == 3), posc_en);
            `CHK("sosc_en", c[5], sosc_en);
            axr(OFF_CFG_WORD, d, r);
            `CHK("cfg_rd", c, d);
            pbc(n);
            `CHK("pb_ticks", 16 >> c[13:12], n);
            axw(OFF_PWR_CTRL, 32'h0000_0800, r);
            `CHK("switch_lock", c[15] ? i[2:0] : OSC_FRC, osc_sel);
        end
        axw(OFF_CFG_WORD, 32'h0, r);
        `CHK("ro_wr", RESP_SLVERR, r);
        axr(4'hC, d, r);
        `CHK("unmap", {RESP_SLVERR, 32'h0}, {r, d});
        axw(OFF_PWR_CTRL, 32'h30, r);
        `CHK("ctrl_wr", RESP_OKAY, r);
        pbc(n);
        `CHK("pb_scaled", 2, n);
        c = mkcfg(OSC_POSC, 1'b1);
        c[15:14] = 2'b00;
        c[9:8] = POSC_HS;
        @(posedge aclk);
        osc_ready <= 1'b0;
        rst(c);
        `CHK("ts_sel", OSC_FRC, osc_sel);
        `CHK("ts_act", 1'b1, two_speed_active);
        @(posedge aclk);
        osc_ready <= 1'b1;
        for (k = 0; k < 10 && two_speed_active !== 1'b0; k++) @(negedge aclk);
        `CHK("ts_done", OSC_POSC, osc_sel);
        hlt(1'b0);
        `CHK("idle_en", 3'b011, {cpu_clk_en, periph_clk_en, system_clock_src_en});
        axr(OFF_PWR_STAT, d, r);
        `CHK("idle_mode", 2'h1, d[1:0]);
        pbc(n);
        `CHK("idle_pb", 16, n);
        wake(10);
        `CHK("idle_wake", 1'b1, cpu_clk_en);
        @(posedge aclk);
        io_out_in <= 8'hA5;
        hlt(1'b1);
        `CHK("sleep_en", 3'b000, {cpu_clk_en, periph_clk_en, system_clock_src_en});
        `CHK("sleep_fail_safe_clk_monitor", 1'b0, fail_safe_clk_monitor_en);
        @(posedge aclk);
        io_out_in <= 8'h5A ^ 8'($urandom);
        osc_ready <= 1'b0;
        repeat (3) @(negedge aclk);
        `CHK("io_hold", 8'hA5, io_out);
        `CHK("wdt_kept", 1'b0, wdt_clear);
        @(posedge aclk);
        wdt_clear_req <= 1'b1;
        @(posedge aclk);
        wdt_clear_req <= 1'b0;
        @(negedge aclk);
        `CHK("wdt_req", 1'b1, wdt_clear);
        wake(0);
        repeat (60)
        begin
            @(negedge aclk);
            `CHK("no_early", 1'b0, cpu_clk_en);
        end
        `CHK("src_back", 1'b1, system_clock_src_en);
        @(posedge aclk);
        osc_ready <= 1'b1;
        for (k = 0; k < 60 && cpu_clk_en !== 1'b1; k++) @(negedge aclk);
        `CHK("woke", 2'b11, {cpu_clk_en, periph_clk_en});
        @(posedge aclk);
        usb_keep_osc <= 1'b1;
        hlt(1'b1);
        `CHK("usb_src", 2'b01, {cpu_clk_en, system_clock_src_en});
        wake(10);
        `CHK("usb_wake", 1'b1, cpu_clk_en);
        // With the oscillator already stable only the start-up timer holds the CPU back.
        @(posedge aclk);
        usb_keep_osc <= 1'b0;
        hlt(1'b1);
        wake(0);
        for (k = 0; k < 60 && cpu_clk_en !== 1'b1; k++) @(negedge aclk);
        `CHK("wake_delay", 1'b1, k > XTAL_START_CYC && k < XTAL_START_CYC + 4);
        axw(OFF_PWR_CTRL, 32'h0000_0D01, r);
        axr(OFF_PWR_CTRL, d, r);
        `CHK("switch_rd", {OSC_LOW_POWER_RC_SOURCE, 32'h0000_0501}, {osc_sel, d});
        results();
    end
endmodule // pwr_clk_ctrl_tb
